/* rtl/ivss_pkg.sv */
// ivss_pkg: constants shared by the vector and shadow-set selection block
// assumes: AXI4-Lite register bus, 32-bit data, 8-bit request numbers
package ivss_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int IRQ_W = 8;
    localparam int IRQ_COUNT = 256;
    localparam int PRI_W = 3;
    localparam int SET_W = 3;
    localparam int OFFSET_W = 17;
    localparam int OFFSET_LSB = 1;
    localparam int FIELD_W = 4;

    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] BASE_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] SHADOW_ADDR = 12'h008;
    localparam logic [ADDR_W-1:0] STATE_ADDR = 12'h00c;
    localparam logic [1:0] OFFSET_TABLE_SEL = 2'h1;

    // field positions
    localparam int CTRL_MULTI_BIT = 0;
    localparam int SV_SHADOW_BIT = 0;
    localparam int SERVICED_LSB = 0;

    // reset values
    localparam logic CTRL_MULTI_RESET = 1'h0;
    localparam logic [DATA_W-1:0] BASE_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] SHADOW_RESET = 32'h00000000;
    localparam logic [IRQ_W-1:0] SERVICED_RESET = 8'h00;
    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 17'h00000;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ivss_pkg

/* rtl/offset_mem_if.sv */
// offset_mem_if: carries the offset table ports between control and memory
// assumes: one write port and two registered read ports on one clock
`timescale 1ns/1ps
`default_nettype none
interface offset_mem_if;
    import ivss_pkg::*;
    logic wr_en;
    logic [IRQ_W-1:0] wr_idx;
    logic [OFFSET_W-1:0] wr_data;
    logic [IRQ_W-1:0] core_idx;
    logic [OFFSET_W-1:0] core_data;
    logic [IRQ_W-1:0] bus_idx;
    logic [OFFSET_W-1:0] bus_data;

    modport ctrl (output wr_en, wr_idx, wr_data, core_idx, bus_idx,
                  input core_data, bus_data);
    modport mem (input wr_en, wr_idx, wr_data, core_idx, bus_idx,
                 output core_data, bus_data);
endinterface : offset_mem_if
`default_nettype wire

/* rtl/offset_mem.sv */
// offset_mem: per-request handler offsets, one entry per request number
// assumes: read data appear one clock after the index
`timescale 1ns/1ps
`default_nettype none
module offset_mem
    import ivss_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // table ports
    offset_mem_if.mem port
);
    logic [OFFSET_W-1:0] table_q [IRQ_COUNT];

    // every entry resets so an unprogrammed request still has a defined vector
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < IRQ_COUNT; i++) begin
                table_q[i] <= OFFSET_RESET;
            end
        end else if (port.wr_en) begin
            table_q[port.wr_idx] <= port.wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port.core_data <= OFFSET_RESET;
            port.bus_data <= OFFSET_RESET;
        end else begin
            port.core_data <= table_q[port.core_idx];
            port.bus_data <= table_q[port.bus_idx];
        end
    end
endmodule : offset_mem
`default_nettype wire

/* rtl/ivss_top.sv */
// ivss_top: handler address and shadow-set selection for serviced requests
// assumes: core pulses irq_take with number and priority; AXI4-Lite master
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ivss_top
    import ivss_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // core request side
    input wire logic irq_take,
    input wire logic [IRQ_W-1:0] irq_number,
    input wire logic [PRI_W-1:0] irq_priority,
    // core vector side
    output logic vector_valid,
    output logic [DATA_W-1:0] vector_address,
    output logic shadow_use,
    output logic [SET_W-1:0] shadow_set,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    offset_mem_if mem_bus ();

    offset_mem u_offset_mem (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .port(mem_bus.mem)
    );

    function automatic logic in_table(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:ADDR_W-2] == OFFSET_TABLE_SEL;
    endfunction : in_table

    function automatic logic [IRQ_W-1:0] table_idx(
        input logic [ADDR_W-1:0] a);
        return a[IRQ_W+1:2];
    endfunction : table_idx

    // reserved codes fall back to set 0 rather than faulting the core
    function automatic logic [SET_W-1:0] pick_set(
        input logic [DATA_W-1:0] pri_sel, input logic [PRI_W-1:0] pri);
        logic [FIELD_W-1:0] field;
        field = pri_sel[pri*FIELD_W +: FIELD_W];
        if (pri == '0 || field[FIELD_W-1]) begin
            return '0;
        end
        return field[SET_W-1:0];
    endfunction : pick_set

    // configuration and state
    logic multi_vector;
    logic [DATA_W-1:0] exception_base_address;
    logic [DATA_W-1:0] shadow_priority_reg;
    logic [IRQ_W-1:0] last_serviced_request;

    // request pipeline: stage one waits on the offset table read
    logic pend_valid;
    logic [IRQ_W-1:0] pend_num;
    logic [PRI_W-1:0] pend_pri;

    assign mem_bus.core_idx = irq_number;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend_valid <= 1'b0;
            pend_num <= '0;
            pend_pri <= '0;
        end else begin
            pend_valid <= irq_take;
            pend_num <= irq_number;
            pend_pri <= irq_priority;
        end
    end

    logic [DATA_W-1:0] next_address;
    logic [DATA_W-1:0] offset_word;
    assign offset_word = {{(DATA_W-OFFSET_W-OFFSET_LSB){1'b0}},
                          mem_bus.core_data, 1'b0};
    // single vector keeps every request at the base itself
    assign next_address = multi_vector ?
        exception_base_address + offset_word : exception_base_address;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vector_valid <= 1'b0;
            vector_address <= '0;
            shadow_use <= 1'b0;
            shadow_set <= '0;
        end else begin
            vector_valid <= pend_valid;
            if (pend_valid) begin
                vector_address <= next_address;
                shadow_set <= pick_set(shadow_priority_reg, pend_pri);
                if (multi_vector) begin
                    shadow_use <= 1'b1;
                end else begin
                    shadow_use <= shadow_priority_reg[SV_SHADOW_BIT];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            last_serviced_request <= SERVICED_RESET;
        end else if (pend_valid) begin
            last_serviced_request <= pend_num;
        end
    end

    // write channel: address and data may arrive in either order
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [DATA_W-1:0] merged;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
        end
    end

    function automatic logic [DATA_W-1:0] apply_strb(
        input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
        input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    logic wr_mapped;
    always_comb begin
        wr_mapped = in_table(aw_addr) || aw_addr == CTRL_ADDR ||
                    aw_addr == BASE_ADDR || aw_addr == SHADOW_ADDR ||
                    aw_addr == STATE_ADDR;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            multi_vector <= CTRL_MULTI_RESET;
            exception_base_address <= BASE_RESET;
            shadow_priority_reg <= SHADOW_RESET;
        end else if (do_write) begin
            if (aw_addr == CTRL_ADDR && w_strb[0]) begin
                multi_vector <= w_data[CTRL_MULTI_BIT];
            end
            if (aw_addr == BASE_ADDR) begin
                exception_base_address <=
                    apply_strb(exception_base_address, w_data, w_strb);
            end
            if (aw_addr == SHADOW_ADDR) begin
                shadow_priority_reg <=
                    apply_strb(shadow_priority_reg, w_data, w_strb);
            end
        end
    end

    // table words take the offset field from any write; bytes without a strobe write as zero
    assign merged = apply_strb('0, w_data, w_strb);
    assign mem_bus.wr_en = do_write && in_table(aw_addr);
    assign mem_bus.wr_idx = table_idx(aw_addr);
    assign mem_bus.wr_data = merged[OFFSET_LSB +: OFFSET_W];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: fixed two-cycle answer so the table read fits
    // rd_wait: address held; rd_look: table word registered from ar_addr
    logic rd_wait;
    logic rd_look;
    logic [ADDR_W-1:0] ar_addr;
    assign mem_bus.bus_idx = table_idx(ar_addr);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            rd_wait <= 1'b0;
            rd_look <= 1'b0;
            ar_addr <= '0;
        end else begin
            rd_look <= rd_wait;
            s_axi_arready <= !s_axi_arready && !rd_wait && !rd_look &&
                             !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_addr <= s_axi_araddr;
                rd_wait <= 1'b1;
            end else begin
                rd_wait <= 1'b0;
            end
        end
    end

    logic [DATA_W-1:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        if (in_table(ar_addr)) begin
            rd_word[OFFSET_LSB +: OFFSET_W] = mem_bus.bus_data;
        end else if (ar_addr == CTRL_ADDR) begin
            rd_word[CTRL_MULTI_BIT] = multi_vector;
        end else if (ar_addr == BASE_ADDR) begin
            rd_word = exception_base_address;
        end else if (ar_addr == SHADOW_ADDR) begin
            rd_word = shadow_priority_reg;
        end else if (ar_addr == STATE_ADDR) begin
            rd_word[SERVICED_LSB +: IRQ_W] = last_serviced_request;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_look) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ivss_top
`default_nettype wire

/* dv/ivss_properties.sv */
// ivss_properties: port-level checks for the vector and shadow-set block
// assumes: bound to ivss_top; config is not rewritten while a vector is due
`timescale 1ns/1ps
`default_nettype none
module ivss_properties
    import ivss_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // core side
    input wire logic irq_take,
    input wire logic [PRI_W-1:0] irq_priority,
    input wire logic vector_valid,
    input wire logic [DATA_W-1:0] vector_address,
    input wire logic shadow_use,
    input wire logic [SET_W-1:0] shadow_set,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] base;
    logic [DATA_W-1:0] pr;
    logic multi;
    logic [PRI_W-1:0] p1;
    logic [PRI_W-1:0] p2;
    logic [3:0] fld;
    logic [SET_W-1:0] want;
    always_ff @(posedge sys_clk) begin
        if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    end
    // copy lags the design by one edge; the bench leaves a gap after writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            multi <= 1'b0;
            base <= '0;
            pr <= '0;
        end else if ($rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY) begin
            if (wa == CTRL_ADDR) multi <= wd[CTRL_MULTI_BIT];
            if (wa == BASE_ADDR) base <= wd;
            if (wa == SHADOW_ADDR) pr <= wd;
        end
    end
    always_ff @(posedge sys_clk) begin
        p1 <= irq_priority;
        p2 <= p1;
    end
    assign fld = pr[4*p2 +: 4];
    assign want = (p2 == '0 || fld[3]) ? '0 : fld[2:0];
    sequence taken_s;
        irq_take;
    endsequence
    sequence answer_s;
        ##2 vector_valid;
    endsequence
    take_to_vector_a: assert property (taken_s |-> answer_s)
        else $error("vector not two cycles after take");
    vector_cause_a: assert property (vector_valid |-> $past(irq_take, 2))
        else $error("vector without a take");
    outputs_hold_a: assert property (!vector_valid |->
        $stable({vector_address, shadow_use, shadow_set}))
        else $error("vector outputs changed between vectors");
    set_select_a: assert property (vector_valid |-> shadow_set == want)
        else $error("wrong shadow set");
    reserved_set_a: assert property (vector_valid && fld[3] |->
        shadow_set == '0)
        else $error("reserved field not set zero");
    multi_use_a: assert property (vector_valid && multi |-> shadow_use)
        else $error("shadow set unused in multi mode");
    single_use_a: assert property (vector_valid && !multi |->
        shadow_use == pr[SV_SHADOW_BIT])
        else $error("single vector shadow use wrong");
    single_addr_a: assert property (vector_valid && !multi |->
        vector_address == base)
        else $error("single vector address not base");
endmodule : ivss_properties
bind ivss_top ivss_properties chk (.*);
`default_nettype wire

/* dv/core_model.sv */
// core_model: processor core that takes requests and latches each vector
// assumes: bench pulses fire with num and pri just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module core_model
    import ivss_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // bench side
    input wire logic fire,
    input wire logic [IRQ_W-1:0] num,
    input wire logic [PRI_W-1:0] pri,
    output logic got,
    output logic [DATA_W+SET_W:0] seen,
    // block side
    output logic irq_take,
    output logic [IRQ_W-1:0] irq_number,
    output logic [PRI_W-1:0] irq_priority,
    input wire logic vector_valid,
    input wire logic [DATA_W-1:0] vector_address,
    input wire logic shadow_use,
    input wire logic [SET_W-1:0] shadow_set
);
    initial begin
        irq_take = 1'b0;
        irq_number = '0;
        irq_priority = '0;
        got = 1'b0;
        seen = '0;
    end
    always @(posedge sys_clk) begin
        irq_take <= fire;
        // between takes the lines toggle, carrying the last request's inverse and the request itself on alternate cycles
        irq_number <= fire ? num : ~irq_number;
        irq_priority <= fire ? pri : ~irq_priority;
        got <= vector_valid;
        if (vector_valid) seen <= {vector_address, shadow_use, shadow_set};
    end
endmodule : core_model
`default_nettype wire

/* dv/interrupt_vector_shadow_select_tb.sv */
// interrupt_vector_shadow_select_tb: self-checking bench for ivss_top
// assumes: core_model on the vector side, bench is the AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_shadow_select_tb
    import ivss_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fire = 1'b0;
    logic [IRQ_W-1:0] num = '0;
    logic [PRI_W-1:0] pri = '0;
    logic got, irq_take, vector_valid, shadow_use;
    logic [DATA_W+SET_W:0] seen;
    logic [IRQ_W-1:0] irq_number;
    logic [PRI_W-1:0] irq_priority;
    logic [DATA_W-1:0] vector_address, s_axi_rdata;
    logic [SET_W-1:0] shadow_set;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic multi = 1'b0;
    logic [DATA_W-1:0] base = '0, pr = '0;
    logic [DATA_W-1:0] offs [IRQ_COUNT] = '{default: '0};
    logic [IRQ_W-1:0] last = '0;
    int failures = 0, n_checks = 0;
    int r;
    int n_got = 0;
    logic [IRQ_W-1:0] idx;
    ivss_top DUT (.*);
    core_model core (.*);
    initial forever #4 sys_clk = ~sys_clk;
    // counts vectors the core model latched, one per take
    always @(posedge sys_clk)
        if (got === 1'b1) n_got <= n_got + 1;
    function automatic logic [DATA_W+SET_W:0] want_vec(
        input logic [IRQ_W-1:0] n, input logic [PRI_W-1:0] p);
        logic [3:0] f;
        logic [SET_W-1:0] s;
        f = pr[4*p +: 4];
        s = (p == '0 || f[3]) ? '0 : f[2:0];
        if (multi) return {base + offs[n], 1'b1, s};
        return {base, pr[SV_SHADOW_BIT], s};
    endfunction : want_vec
    function automatic logic [1:0] resp_of(input logic [ADDR_W-1:0] a);
        if (a <= STATE_ADDR || a[11:10] == OFFSET_TABLE_SEL) return RESP_OKAY;
        return RESP_SLVERR;
    endfunction : resp_of
    function automatic logic [DATA_W-1:0] rval(input logic [ADDR_W-1:0] a);
        if (a[11:10] == OFFSET_TABLE_SEL) return offs[a[9:2]];
        case (a)
            CTRL_ADDR: return {31'h0, multi};
            BASE_ADDR: return base;
            SHADOW_ADDR: return pr;
            STATE_ADDR: return {24'h0, last};
            default: return '0;
        endcase
    endfunction : rval
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic tmo();
        chk(1'b0, "timeout");
        report_and_stop();
    endtask : tmo
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        logic b;
        b = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 64 && !b; i++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        if (!b) tmo();
        chk(s_axi_bresp === resp_of(a), "write response");
        if (resp_of(a) == RESP_OKAY) begin
            if (a == CTRL_ADDR) multi = d[CTRL_MULTI_BIT];
            if (a == BASE_ADDR) base = d;
            if (a == SHADOW_ADDR) pr = d;
            if (a[11:10] == OFFSET_TABLE_SEL) offs[a[9:2]] = d & 32'h0003fffe;
        end
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a);
        int i;
        logic v;
        v = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 64 && !v; i++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            v = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        if (!v) tmo();
        chk(s_axi_rresp === resp_of(a) && s_axi_rdata === rval(a), "read");
    endtask : rd
    task automatic serve(input logic [IRQ_W-1:0] n, input int k);
        logic [PRI_W-1:0] p;
        int g;
        g = n_got;
        repeat (k) begin
            @(posedge sys_clk);
            p = PRI_W'($urandom);
            fire <= 1'b1;
            num <= n;
            pri <= p;
            n = n + 8'h01;
        end
        @(posedge sys_clk);
        fire <= 1'b0;
        // fixed two-edge answer plus the model's own register stages
        repeat (5) @(posedge sys_clk);
        last = n - 8'h01;
        chk(seen === want_vec(last, p), "vector or shadow set");
        chk(n_got == g + k, "vector count");
    endtask : serve
    initial begin
        void'($urandom(32'hd7fd));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (r = 0; r < 5; r++) rd(r == 4 ? 12'h7fc : 12'(4 * r));
        wr(12'h010, 32'hffffffff);
        rd(12'h800);
        wr(STATE_ADDR, 32'h000000ff);
        $display("reset and bus errors done");
        wr(BASE_ADDR, $urandom);
        for (r = 0; r < 2; r++) begin
            wr(SHADOW_ADDR, 32'h76543210 | r);
            serve(IRQ_W'($urandom), 1);
            rd(STATE_ADDR);
        end
        $display("single vector done");
        wr(CTRL_ADDR, 32'h00000001);
        for (r = 0; r < 24; r++) begin
            idx = IRQ_W'($urandom);
            wr({OFFSET_TABLE_SEL, idx, 2'b00}, $urandom);
            rd({OFFSET_TABLE_SEL, idx, 2'b00});
            // corner fields first: sets 2 to 7 and reserved code 8, then set 1 and reserved codes
            if (r < 2) wr(SHADOW_ADDR, r ? 32'h0fedcb10 : 32'h87654320);
            else wr(SHADOW_ADDR, $urandom);
            serve(idx, 1);
            rd(STATE_ADDR);
        end
        $display("multi vector done");
        serve(IRQ_W'($urandom), 6);
        rd(STATE_ADDR);
        repeat (20) @(posedge sys_clk);
        rd(STATE_ADDR);
        $display("back to back done");
        report_and_stop();
    end
endmodule : interrupt_vector_shadow_select_tb
`default_nettype wire
